// ===== dv/rts_sequencer_properties.sv
// Port-level assertions for the reset and start-up sequencer
`timescale 1ns/1ns
module rts_seq_props import rts_pkg::*; #(
  parameter int BOR_FILT = 3
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire rts_evt_s    evt,
  input wire logic        core_reset,
  input wire logic        wake_pulse,
  input wire logic        vector_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the brown-out enable and trip bits, taken from bus writes
  logic [2:0] bor_cfg_q;
  logic [7:0] low_cnt_q;
  logic       supply_low;
  assign supply_low = (bor_cfg_q[1:0] == 2'h3 &&
                       (bor_cfg_q[2] ? evt.below_lo_trip : evt.below_hi_trip)) ||
                      (evt.flash_erasing && evt.below_lo_trip);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bor_cfg_q <= 3'h0;
      low_cnt_q <= 8'h00;
    end else begin
      if (psel && penable && pready && pwrite && paddr == 8'h14) begin
        bor_cfg_q <= pwdata[7:5];
      end
      low_cnt_q <= !supply_low ? 8'h00 : (&low_cnt_q ? low_cnt_q : low_cnt_q + 8'h01);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_access_wait;
    psel && penable && !pready;
  endsequence
  sequence s_por_drop;
    $fell(evt.por_req);
  endsequence
  property p_one_wait;
    s_access_wait |=> pready;
  endproperty
  property p_ready_single;
    pready |=> !pready;
  endproperty
  property p_read_pad;
    pready && !pwrite |-> prdata[31:13] == 19'h0;
  endproperty
  property p_por_holds;
    evt.por_req |=> core_reset;
  endproperty
  property p_powerup_delay_timer_hold;
    s_por_drop |=> core_reset [*8];
  endproperty
  property p_pin_holds;
    !evt.ext_reset_pin_n |-> ##[1:2] core_reset;
  endproperty
  property p_vec_wake;
    vector_req |-> wake_pulse;
  endproperty
  property p_wake_run;
    wake_pulse |-> !core_reset ##1 !wake_pulse;
  endproperty
  property p_bor_trip;
    low_cnt_q == BOR_FILT + 2 |-> ##[0:2] core_reset;
  endproperty
  a_one_wait:     assert property (p_one_wait) else $error("pready not after one wait");
  a_ready_single: assert property (p_ready_single) else $error("pready longer than one cycle");
  a_read_pad:     assert property (p_read_pad) else $error("unused read bits not zero");
  a_por_holds:    assert property (p_por_holds) else $error("power-on not in reset");
  a_powerup_delay_timer_hold:    assert property (p_powerup_delay_timer_hold) else $error("power-up delay cut");
  a_pin_holds:    assert property (p_pin_holds) else $error("pin low without reset");
  a_vec_wake:     assert property (p_vec_wake) else $error("vector without wake");
  a_wake_run:     assert property (p_wake_run) else $error("wake pulse wrong");
  a_bor_trip:     assert property (p_bor_trip) else $error("brown-out missed");
endmodule : rts_seq_props

// ===== dv/rts_sequencer_tb.sv
// Self-checking bench for the reset and start-up sequencer
`timescale 1ns/1ns
module rts_sequencer_tb import rts_pkg::*;;
  localparam int PW = 50;
  // Rows: {reset expected, flash erase, below low, below high, config}
  localparam logic [15:0] BT [5] = '{16'h1600, 16'h16e0, 16'hb6e0, 16'h9640, 16'hf600};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        core_reset, wake_pulse, vector_req, cr_d;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  rts_evt_s    evt;
  int          failures, samples_checked, rst_cnt, wake_cnt, vec_cnt, n, r0;
  rts_sequencer #(.POWERUP_DELAY_TIMER_CNT(PW), .WDT_BASE(4), .BOR_FILT(3)) DUT (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .evt(evt),
    .core_reset(core_reset), .wake_pulse(wake_pulse), .vector_req(vector_req));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cr_d <= core_reset;
    if (core_reset === 1'b1 && cr_d === 1'b0) rst_cnt++;
    if (wake_pulse === 1'b1) wake_cnt++;
    if (vector_req === 1'b1) vec_cnt++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic ok(input logic c);
    chk({31'h0, c}, 32'h1);
  endtask : ok
  // Counts edges until the signal was seen at the wanted level
  task automatic wait_lvl(ref logic s, input logic v, input int lim, output int k);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (s !== v && k < lim);
  endtask : wait_lvl
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic e = 1'b0);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    wait_lvl(pready, 1'b1, 20, n);
    rd = prdata;
    chk({31'h0, pslverr}, {31'h0, e});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk
  task automatic pulse_sleep;
    evt.sleep_instr <= 1'b1;
    @(posedge pclk);
    evt.sleep_instr <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : pulse_sleep
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; cr_d = 1'b0; rst_cnt = 0; wake_cnt = 0; vec_cnt = 0;
    failures = 0; samples_checked = 0;
    evt = 11'h003;  // Pin held low, both oscillator ticks every cycle
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (PW + OST_PERIODS + 60) @(posedge pclk);
    ok(core_reset);
    evt.ext_reset_pin_n <= 1'b1;
    wait_lvl(core_reset, 1'b0, 6, n);
    ok(n <= 3);
    rchk(8'h0c, 32'h18);
    rchk(8'h10, 32'h0);
    apb(1'b1, 8'h0c, 32'h0);
    rchk(8'h0c, 32'h18);
    apb(1'b1, 8'h20, 32'h1, 1'b1);
    apb(1'b0, 8'h11, 32'h0, 1'b1);
    apb(1'b1, 8'h10, 32'h3);
    rchk(8'h10, 32'h3);
    for (int i = 0; i < 5; i++) begin
      r0 = rst_cnt;
      apb(1'b1, 8'h14, {20'h0, BT[i][11:0]});
      evt.below_hi_trip <= BT[i][12];
      evt.below_lo_trip <= BT[i][13];
      evt.flash_erasing <= BT[i][14];
      repeat (8) @(posedge pclk);
      evt.below_hi_trip <= 1'b0;
      evt.below_lo_trip <= 1'b0;
      evt.flash_erasing <= 1'b0;
      wait_lvl(core_reset, 1'b0, PW + 20, n);
      chk(rst_cnt - r0, {31'h0, BT[i][15]});
    end
    rchk(8'h10, 32'h2);
    apb(1'b1, 8'h10, 32'h3);
    apb(1'b1, 8'h14, 32'h660);
    evt.below_hi_trip <= 1'b1;
    repeat (8) @(posedge pclk);
    evt.below_hi_trip <= 1'b0;
    repeat (20) @(posedge pclk);
    evt.below_hi_trip <= 1'b1;
    repeat (8) @(posedge pclk);
    evt.below_hi_trip <= 1'b0;
    wait_lvl(core_reset, 1'b0, PW + 20, n);
    ok(n >= PW && n <= PW + 6);
    rchk(8'h0c, 32'h18);
    apb(1'b1, 8'h10, 32'h3);
    evt.por_req <= 1'b1;
    repeat (3) @(posedge pclk);
    evt.por_req <= 1'b0;
    wait_lvl(core_reset, 1'b0, PW + 20, n);
    rchk(8'h10, 32'h1);
    evt.ext_reset_pin_n <= 1'b0;
    repeat (3) @(posedge pclk);
    ok(core_reset);
    evt.ext_reset_pin_n <= 1'b1;
    wait_lvl(core_reset, 1'b0, 6, n);
    rchk(8'h0c, 32'h18);
    pulse_sleep();
    rchk(8'h0c, 32'h10);
    evt.ext_reset_pin_n <= 1'b0;
    repeat (3) @(posedge pclk);
    evt.ext_reset_pin_n <= 1'b1;
    wait_lvl(core_reset, 1'b0, 6, n);
    rchk(8'h0c, 32'h10);
    // Longest prescale keeps the bus traffic well inside one period
    apb(1'b1, 8'h14, 32'h67f);
    r0 = rst_cnt;
    repeat (10) begin
      repeat (300) @(posedge pclk);
      evt.watchdog_clear_instr <= 1'b1;
      @(posedge pclk);
      evt.watchdog_clear_instr <= 1'b0;
    end
    chk(rst_cnt, r0);
    wait_lvl(core_reset, 1'b1, 700, n);
    ok(n >= 505 && n <= 520);
    wait_lvl(core_reset, 1'b0, 6, n);
    rchk(8'h0c, 32'h0);
    pulse_sleep();
    wait_lvl(wake_pulse, 1'b1, 700, n);
    ok(n < 520);
    rchk(8'h0c, 32'h0);
    apb(1'b1, 8'h14, 32'h660);
    evt.global_irq_enable <= 1'b1;
    pulse_sleep();
    evt.wake_irq <= 1'b1;
    wait_lvl(wake_pulse, 1'b1, 6, n);
    evt.wake_irq <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(vec_cnt, 1);
    rchk(8'h0c, 32'h10);
    apb(1'b1, 8'h14, 32'h260);
    evt.global_irq_enable <= 1'b0;
    pulse_sleep();
    evt.wake_irq <= 1'b1;
    wait_lvl(wake_pulse, 1'b1, 1100, n);
    evt.wake_irq <= 1'b0;
    ok(n >= OST_PERIODS && n <= OST_PERIODS + 6);
    chk(vec_cnt, 1);
    report_and_stop();
  end
endmodule : rts_sequencer_tb

bind rts_sequencer rts_seq_props #(.BOR_FILT(BOR_FILT)) u_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .evt(evt),
  .core_reset(core_reset), .wake_pulse(wake_pulse), .vector_req(vector_req));

// ===== hdl/rts_pkg.sv
// Constants and types of the reset and start-up sequencer
// Function
// - Watchdog fuse set keeps counter running outside the start-up holds
// - Watchdog period from prescaler assign and select
// - Clear watchdog on fuse off, instruction, wake
// - Crystal wake holds watchdog cleared through startup
// - Brown-out enable field: 11 on, 10 awake
// - Trip select bit picks one of two thresholds
// - Supply low past filter time enters brown-out
// - Brown-out during power-up delay restarts full delay
// - Flash erase forces brown-out on, lowest threshold
// - Power-up delay after power-on, then oscillator delay
// - Delays run from power-on; pin release starts execution
// - Crystal modes add 1024 periods after power-up delay; low-power crystal only with the secondary off
// - Other modes use only power-up delay when enabled
// - Brown-out clears bit 0; software sets it
// - Power-on clears bit 1 only; software writes one
// - Timeout and powerdown flags follow each reset cause
// - Power-up delay 64 ms, disabled when bit set
// - Watchdog held in reset during oscillator delay
// - Interrupt wake with enable requests vector jump
package rts_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] CPU_STATUS_IDX    = 8'h03;
  localparam logic [7:0] POWER_CONTROL_IDX = 8'h04;
  localparam logic [7:0] CONFIG_IDX        = 8'h05;

  // Field positions
  localparam int STATUS_PD_BIT  = 3;
  localparam int STATUS_TO_BIT  = 4;
  localparam int POWER_CONTROL_BOR_BIT   = 0;
  localparam int POWER_CONTROL_POR_BIT   = 1;

  // Timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int POWERUP_DELAY_TIMER_TIME_MS    = 64;
  localparam int POWERUP_DELAY_TIMER_CYCLES     = POWERUP_DELAY_TIMER_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int OST_PERIODS     = 1024;
  localparam int BOR_FILTER_NS   = 1000;
  localparam int BOR_FILTER_CYC  = (BOR_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WDT_BASE_TICKS  = 512;

  // Oscillator modes
  localparam logic [2:0] OSC_LOWPOWER_CRYSTAL   = 3'h0;
  localparam logic [2:0] OSC_CRYSTAL_MODE       = 3'h1;
  localparam logic [2:0] OSC_HIGHSPEED_CRYSTAL  = 3'h2;
  localparam logic [2:0] OSC_RESISTOR_CAP       = 3'h3;
  localparam logic [2:0] OSC_INTERNAL           = 3'h4;
  localparam logic [2:0] OSC_EXTERNAL_CLOCK     = 3'h5;
  localparam logic [2:0] OSC_SECONDARY          = 3'h6;

  // Brown-out enable field values
  localparam logic [1:0] BOR_ALWAYS_ON = 2'h3;
  localparam logic [1:0] BOR_AWAKE_ON  = 2'h2;

  typedef struct packed {
    logic       secondary_osc_on;
    logic [2:0] osc_mode;
    logic       powerup_delay_off;
    logic       brownout_trip_sel;
    logic [1:0] brownout_enable_sel;
    logic [2:0] prescale_select;
    logic       prescaler_assign;
    logic       watchdog_enable_fuse;
  } rts_cfg_s;

  localparam rts_cfg_s CFG_RESET = 13'h0000;

  typedef struct packed {
    logic por_req;
    logic below_hi_trip;
    logic below_lo_trip;
    logic ext_reset_pin_n;
    logic sleep_instr;
    logic wake_irq;
    logic global_irq_enable;
    logic watchdog_clear_instr;
    logic flash_erasing;
    logic wdt_tick;
    logic osc_tick;
  } rts_evt_s;

  typedef enum logic [3:0] {
    ST_POR_HOLD, ST_BOR_HOLD, ST_POWERUP_DELAY_TIMER, ST_OST, ST_PIN_WAIT,
    ST_RUN, ST_PIN_RST, ST_WDT_RST, ST_SLEEP, ST_WAKE_OST
  } rts_seq_e;

endpackage : rts_pkg

// ===== hdl/rts_sequencer.sv
// Reset and start-up sequencer with watchdog and APB register slave
`timescale 1ns/1ns
module rts_sequencer import rts_pkg::*; #(
  parameter int POWERUP_DELAY_TIMER_CNT = POWERUP_DELAY_TIMER_CYCLES,
  parameter int WDT_BASE = WDT_BASE_TICKS,
  parameter int BOR_FILT = BOR_FILTER_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire rts_evt_s    evt,
  output logic             core_reset,
  output logic             wake_pulse,
  output logic             vector_req
);

  // Oscillator ticks come in as one-cycle enables on pclk. Rates above pclk are lost,
  // so the counts are only as fine as the bus clock.

  // One counter serves the power-up delay and the oscillator delay
  localparam int PW_W  = $clog2(POWERUP_DELAY_TIMER_CNT + 1);
  localparam int CNT_W = (PW_W > 11) ? PW_W : 11;
  localparam int WDT_W = $clog2(WDT_BASE) + 9;
  localparam int BF_W  = $clog2(BOR_FILT + 2);

  // Whole block state, registered in one place
  typedef struct packed {
    rts_seq_e           st;
    logic [CNT_W-1:0]   cnt;
    logic [BF_W-1:0]    bor_cnt;
    logic [WDT_W-1:0]   wdt;
    logic               timeout_flag;
    logic               powerdown_flag;
    logic               por_flag;
    logic               brownout_flag;
    logic               wake_by_irq;
    rts_cfg_s           cfg;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
    logic               core_rst;
    logic               wake;
    logic               vec;
  } rts_state_s;

  rts_state_s s_q;
  rts_state_s s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Derived conditions

  logic             xtal_mode;
  logic             bor_enabled;
  logic             supply_low;
  logic             bor_trip;
  logic [WDT_W-1:0] wdt_limit;
  logic             wdt_expired;
  logic             access;
  logic [7:0]       reg_idx;
  logic             addr_ok;
  logic             osc_delay_done;
  logic             sleep_wake;

  always_comb begin
    // Low-power crystal needs the oscillator delay only with the secondary off
    xtal_mode = (s_q.cfg.osc_mode == OSC_CRYSTAL_MODE) ||
                (s_q.cfg.osc_mode == OSC_HIGHSPEED_CRYSTAL) ||
                ((s_q.cfg.osc_mode == OSC_LOWPOWER_CRYSTAL) &&
                 !s_q.cfg.secondary_osc_on);
    if (evt.flash_erasing) begin
      bor_enabled = 1'b1;
      supply_low  = evt.below_lo_trip;
    end else begin
      bor_enabled = (s_q.cfg.brownout_enable_sel == BOR_ALWAYS_ON) ||
                    ((s_q.cfg.brownout_enable_sel == BOR_AWAKE_ON) &&
                     (s_q.st != ST_SLEEP) && (s_q.st != ST_WAKE_OST));
      supply_low  = s_q.cfg.brownout_trip_sel ? evt.below_lo_trip
                                              : evt.below_hi_trip;
    end
    // Trip only once the supply has stayed low beyond the filter window
    bor_trip = bor_enabled && supply_low &&
               (s_q.bor_cnt >= BF_W'(BOR_FILT));
    // The shared prescaler stretches the period only when assigned here
    wdt_limit = s_q.cfg.prescaler_assign
              ? (WDT_W'(WDT_BASE) << s_q.cfg.prescale_select)
              : WDT_W'(WDT_BASE);
    wdt_expired = s_q.cfg.watchdog_enable_fuse && (s_q.wdt >= wdt_limit - 1'b1) &&
                  evt.wdt_tick;
    // Only aligned words of the three registers are mapped
    access  = psel && penable;
    reg_idx = {2'h0, paddr[7:2]};
    addr_ok = (paddr[1:0] == 2'h0) &&
              ((reg_idx == CPU_STATUS_IDX) || (reg_idx == POWER_CONTROL_IDX) ||
               (reg_idx == CONFIG_IDX));
    // Non-crystal clocks need no oscillator delay at all
    osc_delay_done = !xtal_mode || (s_q.cnt >= CNT_W'(OST_PERIODS));
    // Either a watchdog expiry or an interrupt ends sleep
    sleep_wake     = wdt_expired || evt.wake_irq;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d       = s_q;
    s_d.wake  = 1'b0;
    s_d.vec   = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Brown-out filter counts consecutive low cycles
    // Saturates at the window, so a long dip trips only once
    if (bor_enabled && supply_low) begin
      if (s_q.bor_cnt < BF_W'(BOR_FILT)) begin
        s_d.bor_cnt = s_q.bor_cnt + 1'b1;
      end
    end else begin
      s_d.bor_cnt = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Software writes to the flag register; hardware causes below override
    // The status word is read-only: writes to it are dropped silently
    if (access && s_q.pready && pwrite) begin
      if (reg_idx == POWER_CONTROL_IDX && paddr[1:0] == 2'h0) begin
        s_d.brownout_flag = pwdata[POWER_CONTROL_BOR_BIT];
        s_d.por_flag      = pwdata[POWER_CONTROL_POR_BIT];
      end
      if (reg_idx == CONFIG_IDX && paddr[1:0] == 2'h0) begin
        s_d.cfg = rts_cfg_s'(pwdata[12:0]);
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    case (s_q.st)
      ST_POR_HOLD: begin
        // Power-up delay may start only once power-on has ended
        s_d.cnt = '0;
        if (!evt.por_req) begin
          s_d.st = s_q.cfg.powerup_delay_off ? ST_OST : ST_POWERUP_DELAY_TIMER;
        end
      end
      ST_BOR_HOLD: begin
        // Held for as long as the supply stays low
        s_d.cnt = '0;
        if (!(bor_enabled && supply_low)) begin
          s_d.st = s_q.cfg.powerup_delay_off ? ST_OST : ST_POWERUP_DELAY_TIMER;
        end
      end
      ST_POWERUP_DELAY_TIMER: begin
        // Counts regardless of the pin: delays run from the power-on pulse
        if (s_q.cnt >= CNT_W'(POWERUP_DELAY_TIMER_CNT - 1)) begin
          s_d.cnt = '0;
          s_d.st  = ST_OST;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      ST_OST: begin
        if (osc_delay_done) begin
          s_d.cnt = '0;
          s_d.st  = ST_PIN_WAIT;
        end else if (evt.osc_tick) begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      ST_PIN_WAIT: begin
        // Delays are over; execution waits only for the pin
        if (evt.ext_reset_pin_n) begin
          s_d.st = ST_RUN;
        end
      end
      ST_RUN: begin
        // A pin reset while running leaves both status flags as they are
        if (!evt.ext_reset_pin_n) begin
          s_d.st = ST_PIN_RST;
        end else if (wdt_expired) begin
          s_d.st           = ST_WDT_RST;
          s_d.timeout_flag = 1'b0;
        end else if (evt.sleep_instr) begin
          s_d.st             = ST_SLEEP;
          s_d.timeout_flag   = 1'b1;
          s_d.powerdown_flag = 1'b0;
        end
      end
      ST_PIN_RST: begin
        if (evt.ext_reset_pin_n) begin
          s_d.st = ST_RUN;
        end
      end
      ST_WDT_RST: begin
        // A watchdog reset lasts one cycle
        s_d.st = ST_RUN;
      end
      ST_SLEEP: begin
        // The pin has priority over the watchdog and interrupt wake
        s_d.cnt = '0;
        if (!evt.ext_reset_pin_n) begin
          s_d.st             = ST_PIN_RST;
          s_d.timeout_flag   = 1'b1;
          s_d.powerdown_flag = 1'b0;
        end else if (sleep_wake) begin
          s_d.wake_by_irq = !wdt_expired && evt.wake_irq;
          if (wdt_expired) begin
            s_d.timeout_flag   = 1'b0;
            s_d.powerdown_flag = 1'b0;
          end
          s_d.st = ST_WAKE_OST;
        end
      end
      ST_WAKE_OST: begin
        // No power-up delay on wake; oscillator delay only for crystals
        // The pin reset still wins while the oscillator settles
        if (!evt.ext_reset_pin_n) begin
          s_d.cnt            = '0;
          s_d.st             = ST_PIN_RST;
          s_d.timeout_flag   = 1'b1;
          s_d.powerdown_flag = 1'b0;
        end else if (osc_delay_done) begin
          s_d.cnt  = '0;
          s_d.st   = ST_RUN;
          s_d.wake = 1'b1;
          s_d.vec  = s_q.wake_by_irq && evt.global_irq_enable;
        end else if (evt.osc_tick) begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      default: begin
        // An illegal code falls back to the power-on hold
        s_d.st = ST_POR_HOLD;
      end
    endcase

    ////////////////////////////////////////////////////////////////////////
    // Brown-out restarts the whole start-up, also mid power-up delay
    if (bor_trip && !evt.por_req) begin
      s_d.st             = ST_BOR_HOLD;
      s_d.cnt            = '0;
      s_d.brownout_flag  = 1'b0;
      s_d.timeout_flag   = 1'b1;
      s_d.powerdown_flag = 1'b1;
    end
    if (evt.por_req) begin
      s_d.st             = ST_POR_HOLD;
      s_d.cnt            = '0;
      s_d.por_flag       = 1'b0;
      s_d.timeout_flag   = 1'b1;
      s_d.powerdown_flag = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog counter
    // The fuse alone enables it; the count goes on through sleep
    // Expiry restarts the count for the next period
    if (!s_q.cfg.watchdog_enable_fuse || evt.watchdog_clear_instr ||
        wdt_expired) begin
      s_d.wdt = '0;
    end else if (s_d.st == ST_OST || s_d.st == ST_WAKE_OST) begin
      // The oscillator delay borrows the ripple counter
      s_d.wdt = '0;
    end else if (s_q.st == ST_SLEEP && s_d.st != ST_SLEEP) begin
      // Any exit from sleep restarts the period
      s_d.wdt = '0;
    end else if (s_d.st == ST_POR_HOLD || s_d.st == ST_BOR_HOLD ||
                 s_d.st == ST_POWERUP_DELAY_TIMER) begin
      s_d.wdt = '0;
    end else if (evt.wdt_tick) begin
      s_d.wdt = s_q.wdt + 1'b1;
    end

    // Sleep and the wake delay keep the core out of reset
    s_d.core_rst = (s_d.st != ST_RUN) && (s_d.st != ST_SLEEP) &&
                   (s_d.st != ST_WAKE_OST);

    ////////////////////////////////////////////////////////////////////////
    // APB: one wait state, answer registered
    if (access && !s_q.pready) begin
      s_d.pready  = 1'b1;
      // Holes and misaligned addresses answer with an error
      s_d.pslverr = !addr_ok;
      s_d.prdata  = 32'h0000_0000;
      if (!pwrite && addr_ok) begin
        case (reg_idx)
          CPU_STATUS_IDX: begin
            s_d.prdata[STATUS_TO_BIT] = s_q.timeout_flag;
            s_d.prdata[STATUS_PD_BIT] = s_q.powerdown_flag;
          end
          POWER_CONTROL_IDX: begin
            s_d.prdata[POWER_CONTROL_BOR_BIT] = s_q.brownout_flag;
            s_d.prdata[POWER_CONTROL_POR_BIT] = s_q.por_flag;
          end
          CONFIG_IDX: begin
            s_d.prdata[12:0] = s_q.cfg;
          end
          default: begin
            s_d.prdata = 32'h0000_0000;
          end
        endcase
      end
    end else begin
      s_d.pready  = 1'b0;
      s_d.pslverr = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Bus reset acts as a power-on: both status flags come up set
      s_q                <= '0;
      s_q.st             <= ST_POR_HOLD;
      s_q.cfg            <= CFG_RESET;
      s_q.timeout_flag   <= 1'b1;
      s_q.powerdown_flag <= 1'b1;
      s_q.core_rst       <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs come straight from the state register

  assign pready     = s_q.pready;
  assign prdata     = s_q.prdata;
  assign pslverr    = s_q.pslverr;
  assign core_reset = s_q.core_rst;
  assign wake_pulse = s_q.wake;
  assign vector_req = s_q.vec;

endmodule : rts_sequencer
